// ---- logic/standby_wake_ctrl.sv ----
// Standby wake controller: APB registers, power-mode sequencer,
// interval timer and window converter.
// Assumes a single 50 MHz clock; the subclock arrives as a pin.
//
// Operation
// - Timer counts through standby, interrupting at each 5 second period.
// - Timer period end is the converter's hardware trigger.
// - Timer counts subclock through a division ratio and a period count.
// - Disabling stops counting; re-enabling restarts the count from zero.
// - Timer event in standby enters snooze (snoozeEnable, hwMode, compEnable set), else normal; one conversion runs unless trigSoftOnly is set.
// - Result within 2048..4095 raises match and returns to normal mode.
// - Result outside the window returns to standby until next period.
// - Enabling the voltage comparator starts a scan in trigger-free mode.
// - Status shows a scan in progress or idle.
// - Each result is 12 bits, read as a 16-bit word.
// - Scan and operation settings pick channel, source, test, mode, more.
//
// Design decisions made here: the register offsets and register access over APB.
`default_nettype none
module standby_wake_ctrl #(
  parameter logic [31:0] PERIOD_RESET = wake_pkg::TIMER_PERIOD_RESET
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Power control
  input wire logic sleepRequest,
  output wake_pkg::power_mode_t powerMode,
  // Subclock pin
  input wire logic subclockIn,
  // Analog front end
  input wire logic [11:0] sampleData,
  output logic sampleHold,
  output logic [3:0] frontChannel,
  output logic frontExternal,
  output logic [1:0] frontVref,
  // Interrupt
  output logic irq
);
  wake_pkg::timer_cfg_t timerCfg;
  logic [31:0] timerPeriod;
  wake_pkg::adc_cfg_t adcCfg;
  wake_pkg::scan_cfg_t scanCfg;
  logic [11:0] lowerBound;
  logic [11:0] upperBound;
  logic [3:0] irqStatus;
  logic [3:0] irqMask;
  logic [3:0] irqEvents;

  logic [31:0] timerCount;
  logic timerEvent;
  logic adcBusy;
  logic [11:0] adcResult;
  logic adcDone;
  logic adcMatch;
  logic adcMiss;
  logic adcTrigger;

  logic [2:0] subSync;
  logic subLevel;
  logic subclockTick;

  logic setupPhase;
  logic accessPhase;
  logic writeStrobe;
  logic readStrobe;
  logic mapped;
  logic [31:0] next_prdata;
  wake_pkg::power_mode_t next_powerMode;

  function automatic logic isMapped(input logic [7:0] addr);
    unique case (addr)
      wake_pkg::OFF_TIMER_CTRL,
      wake_pkg::OFF_TIMER_PERIOD,
      wake_pkg::OFF_TIMER_COUNT,
      wake_pkg::OFF_ADC_CTRL,
      wake_pkg::OFF_ADC_SCAN,
      wake_pkg::OFF_ADC_LOWER,
      wake_pkg::OFF_ADC_UPPER,
      wake_pkg::OFF_ADC_RESULT,
      wake_pkg::OFF_ADC_STATUS,
      wake_pkg::OFF_IRQ_STATUS,
      wake_pkg::OFF_IRQ_MASK: isMapped = 1'b1;
      default: isMapped = 1'b0;
    endcase
  endfunction

  // Subclock pin: three stages, an edge counts once stages two and three
  // agree, so a metastable first stage never reaches the counter.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      subSync <= 3'b000;
      subLevel <= 1'b0;
    end else begin
      subSync <= {subSync[1:0], subclockIn};
      if (subSync[2] == subSync[1]) begin
        subLevel <= subSync[2];
      end
    end
  end

  // One tick per settled rising edge; the subclock must stay well below
  // a quarter of the system clock or its edges merge.
  assign subclockTick = (subSync[2] == subSync[1]) && subSync[2] &&
    !subLevel;

  // APB decode; zero wait states, read data captured in the setup cycle
  assign setupPhase = psel && !penable;
  assign accessPhase = psel && penable;
  assign mapped = isMapped(paddr);
  assign writeStrobe = accessPhase && pwrite && mapped;
  assign readStrobe = accessPhase && !pwrite && mapped;
  assign pready = accessPhase;
  assign pslverr = accessPhase && !mapped;

  always_comb begin
    next_prdata = 32'h0000_0000;
    unique case (paddr)
      wake_pkg::OFF_TIMER_CTRL: next_prdata[5:0] = timerCfg;
      wake_pkg::OFF_TIMER_PERIOD: next_prdata = timerPeriod;
      wake_pkg::OFF_TIMER_COUNT: next_prdata = timerCount;
      wake_pkg::OFF_ADC_CTRL: next_prdata[8:0] = adcCfg;
      wake_pkg::OFF_ADC_SCAN: next_prdata[5:0] = scanCfg;
      wake_pkg::OFF_ADC_LOWER: next_prdata[11:0] = lowerBound;
      wake_pkg::OFF_ADC_UPPER: next_prdata[11:0] = upperBound;
      wake_pkg::OFF_ADC_RESULT: next_prdata[15:0] = {4'h0, adcResult};
      wake_pkg::OFF_ADC_STATUS: next_prdata[2:0] = {powerMode, adcBusy};
      wake_pkg::OFF_IRQ_STATUS: next_prdata[3:0] = irqStatus;
      wake_pkg::OFF_IRQ_MASK: next_prdata[3:0] = irqMask;
      default: next_prdata = 32'h0000_0000;
    endcase
  end

  // Registered at setup so the access cycle needs no wait state; a value
  // that changes in that one cycle is reported as it stood at setup.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      prdata <= 32'h0000_0000;
    end else if (setupPhase) begin
      prdata <= pwrite ? 32'h0000_0000 : next_prdata;
    end
  end

  // Timer registers
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      timerCfg <= '0;
      timerPeriod <= PERIOD_RESET;
    end else if (writeStrobe) begin
      if (paddr == wake_pkg::OFF_TIMER_CTRL) begin
        timerCfg <= pwdata[5:0];
      end
      if (paddr == wake_pkg::OFF_TIMER_PERIOD) begin
        timerPeriod <= pwdata;
      end
    end
  end

  // Converter registers
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      adcCfg <= '0;
      scanCfg <= '{testMode: 1'b0, extSource: 1'b0,
        channel: wake_pkg::SCAN_CHANNEL_RESET};
      lowerBound <= wake_pkg::LOWER_RESET;
      upperBound <= wake_pkg::UPPER_RESET;
    end else if (writeStrobe) begin
      unique case (paddr)
        wake_pkg::OFF_ADC_CTRL: adcCfg <= pwdata[8:0];
        wake_pkg::OFF_ADC_SCAN: scanCfg <= pwdata[5:0];
        wake_pkg::OFF_ADC_LOWER: lowerBound <= pwdata[11:0];
        wake_pkg::OFF_ADC_UPPER: upperBound <= pwdata[11:0];
        default: ;
      endcase
    end
  end

  // Interrupts: sticky, read clears only what the read reported, and a
  // fresh event wins over the clear so none is lost.
  always_comb begin
    irqEvents = '0;
    irqEvents[wake_pkg::IRQ_TIMER] = timerEvent;
    irqEvents[wake_pkg::IRQ_MATCH] = adcMatch;
    irqEvents[wake_pkg::IRQ_DONE] = adcDone;
    irqEvents[wake_pkg::IRQ_MISS] = adcMiss;
  end

  for (genvar b = 0; b < wake_pkg::IRQ_W; b++) begin : g_irq
    always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
        irqStatus[b] <= 1'b0;
      end else if (irqEvents[b]) begin
        irqStatus[b] <= 1'b1;
      end else if (readStrobe && paddr == wake_pkg::OFF_IRQ_STATUS &&
          prdata[b]) begin
        irqStatus[b] <= 1'b0;
      end
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      irqMask <= 4'h0;
    end else if (writeStrobe && paddr == wake_pkg::OFF_IRQ_MASK) begin
      irqMask <= pwdata[3:0];
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irqStatus & irqMask);
    end
  end

  // Power sequencer. The snooze bit is left to software to clear after
  // waking; while it stays set a later standby still uses snooze.
  always_comb begin
    next_powerMode = powerMode;
    unique case (powerMode)
      wake_pkg::PM_NORMAL: begin
        if (sleepRequest) begin
          next_powerMode = wake_pkg::PM_STANDBY;
        end
      end
      wake_pkg::PM_STANDBY: begin
        if (timerEvent) begin
          if (adcCfg.snoozeEnable && adcCfg.hwMode && adcCfg.compEnable) begin
            next_powerMode = wake_pkg::PM_SNOOZE;
          end else begin
            next_powerMode = wake_pkg::PM_NORMAL;
          end
        end
      end
      wake_pkg::PM_SNOOZE: begin
        if (adcMatch) begin
          next_powerMode = wake_pkg::PM_NORMAL;
        end else if (adcMiss) begin
          next_powerMode = wake_pkg::PM_STANDBY;
        end
      end
      default: next_powerMode = wake_pkg::PM_NORMAL;
    endcase
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      powerMode <= wake_pkg::PM_NORMAL;
    end else begin
      powerMode <= next_powerMode;
    end
  end

  // In standby the trigger only reaches the converter with snooze armed
  assign adcTrigger = timerEvent &&
    (powerMode == wake_pkg::PM_NORMAL || adcCfg.snoozeEnable);

  interval_timer_32bit u_timer (
    .clock(clock),
    .rst_n(rst_n),
    .cfg(timerCfg),
    .period(timerPeriod),
    .subclockTick(subclockTick),
    .count(timerCount),
    .periodEnd(timerEvent)
  );

  window_adc u_adc (
    .clock(clock),
    .rst_n(rst_n),
    .cfg(adcCfg),
    .scan(scanCfg),
    .lower(lowerBound),
    .upper(upperBound),
    .hwTrigger(adcTrigger),
    .sampleData(sampleData),
    .sampleHold(sampleHold),
    .busy(adcBusy),
    .result(adcResult),
    .done(adcDone),
    .match(adcMatch),
    .miss(adcMiss)
  );

  // Front-end selects come straight from registers
  assign frontChannel = scanCfg.channel;
  assign frontExternal = scanCfg.extSource;
  assign frontVref = adcCfg.vref;
endmodule // standby_wake_ctrl
`default_nettype wire

// ---- include/wake_pkg.sv ----
// Shared constants and carrier types for the standby wake block.
// Assumes a 50 MHz system clock and a 32768 Hz subclock pin.
`default_nettype none
package wake_pkg;
  // Register byte offsets
  localparam logic [7:0] OFF_TIMER_CTRL = 8'h00;
  localparam logic [7:0] OFF_TIMER_PERIOD = 8'h04;
  localparam logic [7:0] OFF_TIMER_COUNT = 8'h08;
  localparam logic [7:0] OFF_ADC_CTRL = 8'h0C;
  localparam logic [7:0] OFF_ADC_SCAN = 8'h10;
  localparam logic [7:0] OFF_ADC_LOWER = 8'h14;
  localparam logic [7:0] OFF_ADC_UPPER = 8'h18;
  localparam logic [7:0] OFF_ADC_RESULT = 8'h1C;
  localparam logic [7:0] OFF_ADC_STATUS = 8'h20;
  localparam logic [7:0] OFF_IRQ_STATUS = 8'h24;
  localparam logic [7:0] OFF_IRQ_MASK = 8'h28;

  // Interrupt status bit positions
  localparam int IRQ_TIMER = 0;
  localparam int IRQ_MATCH = 1;
  localparam int IRQ_DONE = 2;
  localparam int IRQ_MISS = 3;
  localparam int IRQ_W = 4;

  // Timing
  localparam int CLOCK_HZ = 50000000;
  localparam int SUBCLK_HZ = 32768;
  localparam int TIMER_PERIOD_S = 5;
  localparam logic [31:0] TIMER_PERIOD_RESET =
    32'(TIMER_PERIOD_S * SUBCLK_HZ);
  localparam logic [7:0] CONV_CYCLES = 8'h10;

  // Reset values
  localparam logic [3:0] SCAN_CHANNEL_RESET = 4'h1;
  localparam logic [11:0] LOWER_RESET = 12'h800;
  localparam logic [11:0] UPPER_RESET = 12'hFFF;
  localparam logic [11:0] TEST_RESULT = 12'hFFF;

  typedef enum logic [1:0] {
    PM_NORMAL = 2'b00,
    PM_STANDBY = 2'b01,
    PM_SNOOZE = 2'b10
  } power_mode_t;

  // Timer control word, bit 0 upward: enable, source, division exponent
  typedef struct packed {
    logic [3:0] divExp;
    logic srcSystem;
    logic enable;
  } timer_cfg_t;

  // Converter operation word, bit 0 upward
  typedef struct packed {
    logic trigSoftOnly;
    logic [1:0] clkDiv;
    logic [1:0] vref;
    logic repeatMode;
    logic hwMode;
    logic snoozeEnable;
    logic compEnable;
  } adc_cfg_t;

  // Converter scan word, bit 0 upward
  typedef struct packed {
    logic testMode;
    logic extSource;
    logic [3:0] channel;
  } scan_cfg_t;
endpackage
`default_nettype wire

// ---- logic/interval_timer_32bit.sv ----
// Interval timer channel: prescaler plus 32-bit period counter.
// Assumes subclockTick is a one-cycle pulse in the system clock domain.
`default_nettype none
module interval_timer_32bit (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Setup
  input wire wake_pkg::timer_cfg_t cfg,
  input wire logic [31:0] period,
  input wire logic subclockTick,
  // Status
  output logic [31:0] count,
  output logic periodEnd
);
  logic [15:0] prescale;
  logic enableSeen;
  logic srcTick;
  logic divTick;
  logic [31:0] lastCount;

  assign srcTick = cfg.srcSystem ? 1'b1 : subclockTick;
  assign divTick = srcTick &&
    (prescale == 16'((17'h1 << cfg.divExp) - 17'h1));
  assign lastCount = (period == 32'h0) ? 32'h0 : period - 32'h1;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      enableSeen <= 1'b0;
    end else begin
      enableSeen <= cfg.enable;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      prescale <= 16'h0000;
      count <= 32'h0000_0000;
      periodEnd <= 1'b0;
    end else begin
      periodEnd <= 1'b0;
      if (!cfg.enable || !enableSeen) begin
        // Held at zero while off and on the first enabled cycle
        prescale <= 16'h0000;
        count <= 32'h0000_0000;
      end else if (srcTick) begin
        prescale <= divTick ? 16'h0000 : prescale + 16'h0001;
        if (divTick) begin
          if (count >= lastCount) begin
            count <= 32'h0000_0000;
            periodEnd <= 1'b1;
          end else begin
            count <= count + 32'h0000_0001;
          end
        end
      end
    end
  end
endmodule // interval_timer_32bit
`default_nettype wire

// ---- logic/window_adc.sv ----
// Converter sequencer with window compare on each 12-bit result.
// Assumes the analog front end presents sampleData on the system clock.
`default_nettype none
module window_adc (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Setup
  input wire wake_pkg::adc_cfg_t cfg,
  input wire wake_pkg::scan_cfg_t scan,
  input wire logic [11:0] lower,
  input wire logic [11:0] upper,
  // Starts
  input wire logic hwTrigger,
  // Front end
  input wire logic [11:0] sampleData,
  output logic sampleHold,
  // Results
  output logic busy,
  output logic [11:0] result,
  output logic done,
  output logic match,
  output logic miss
);
  logic compSeen;
  logic swStart;
  logic start;
  logic [10:0] timer;
  logic [11:0] value;
  logic [10:0] convLength;

  // Software start in trigger-free mode, or repeat after each result
  assign swStart = !cfg.hwMode && cfg.compEnable &&
    (!compSeen || (cfg.repeatMode && done));
  assign start = !busy && (swStart ||
    (cfg.hwMode && cfg.compEnable && !cfg.trigSoftOnly && hwTrigger));
  assign convLength = 11'({3'h0, wake_pkg::CONV_CYCLES} << cfg.clkDiv);
  assign value = scan.testMode ? wake_pkg::TEST_RESULT : sampleData;
  assign sampleHold = busy;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      compSeen <= 1'b0;
    end else begin
      compSeen <= cfg.compEnable;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      busy <= 1'b0;
      timer <= 11'h000;
    end else if (start) begin
      busy <= 1'b1;
      timer <= convLength - 11'h001;
    end else if (busy) begin
      timer <= timer - 11'h001;
      busy <= (timer != 11'h000);
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      result <= 12'h000;
      done <= 1'b0;
      match <= 1'b0;
      miss <= 1'b0;
    end else begin
      done <= 1'b0;
      match <= 1'b0;
      miss <= 1'b0;
      if (busy && timer == 11'h000) begin
        result <= value;
        done <= 1'b1;
        // Bounds count as inside
        if (value >= lower && value <= upper) begin
          match <= 1'b1;
        end else begin
          miss <= 1'b1;
        end
      end
    end
  end
endmodule // window_adc
`default_nettype wire

// ---- tb/wake_checker.sv ----
// Port-level checker for the standby wake controller.
// Assumes it is bound onto standby_wake_ctrl; one clock domain.
`default_nettype none
module wake_checker #(
  parameter logic [31:0] PERIOD_RESET = wake_pkg::TIMER_PERIOD_RESET
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Power and front end
  input wire logic sleepRequest,
  input wire wake_pkg::power_mode_t powerMode,
  input wire logic subclockIn,
  input wire logic [11:0] sampleData,
  input wire logic sampleHold,
  input wire logic [3:0] frontChannel,
  input wire logic frontExternal,
  input wire logic [1:0] frontVref,
  input wire logic irq
);
  logic acc;
  logic compSeen;
  assign acc = psel && penable;
  // Tracks the written compare enable so only a real rise is checked
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      compSeen <= 1'b0;
    end else if (acc && pwrite && paddr == wake_pkg::OFF_ADC_CTRL) begin
      compSeen <= pwdata[0];
    end
  end
  default clocking @(posedge clock);
  endclocking
  default disable iff (!rst_n);
  AST_SLEEP: assert property (
    powerMode == wake_pkg::PM_NORMAL && sleepRequest |=>
    powerMode == wake_pkg::PM_STANDBY) else $error("no standby entry");
  AST_SNOOZE_SRC: assert property (
    powerMode == wake_pkg::PM_SNOOZE &&
    $past(powerMode) != wake_pkg::PM_SNOOZE |->
    $past(powerMode) == wake_pkg::PM_STANDBY) else $error("bad snooze");
  AST_SNOOZE_CONV: assert property (
    $rose(powerMode == wake_pkg::PM_SNOOZE) |-> ##[0:2] sampleHold)
    else $error("snooze without conversion");
  AST_SNOOZE_HOLD: assert property (
    $rose(powerMode == wake_pkg::PM_SNOOZE) |->
    (powerMode == wake_pkg::PM_SNOOZE)[*8]) else $error("snooze too short");
  AST_SNOOZE_EXIT: assert property (
    $past(powerMode) == wake_pkg::PM_SNOOZE &&
    powerMode != wake_pkg::PM_SNOOZE |-> !sampleHold && powerMode != 2'b11)
    else $error("snooze left mid conversion");
  AST_RESULT_WIDTH: assert property (
    acc && !pwrite && paddr == wake_pkg::OFF_ADC_RESULT |->
    prdata[31:12] == 20'h00000) else $error("result wider than 12 bits");
  AST_STATUS_BUSY: assert property (
    acc && !pwrite && paddr == wake_pkg::OFF_ADC_STATUS |->
    prdata[0] == $past(sampleHold) && prdata[2:1] == $past(powerMode))
    else $error("status mismatch");
  AST_SCAN_SETUP: assert property (
    acc && pwrite && paddr == wake_pkg::OFF_ADC_SCAN |=>
    frontChannel == $past(pwdata[3:0]) && frontExternal == $past(pwdata[4]))
    else $error("scan setup not applied");
  AST_VREF_SETUP: assert property (
    acc && pwrite && paddr == wake_pkg::OFF_ADC_CTRL |=>
    frontVref == $past(pwdata[5:4])) else $error("vref not applied");
  AST_SOFT_START: assert property (
    acc && pwrite && paddr == wake_pkg::OFF_ADC_CTRL && pwdata[0] &&
    !pwdata[2] && !compSeen && !sampleHold |=> ##[0:2] sampleHold)
    else $error("compare enable did not start scan");
  AST_BUSY_SPAN: assert property (
    $rose(sampleHold) |-> sampleHold[*8]) else $error("busy too short");
endmodule // wake_checker
bind standby_wake_ctrl wake_checker #(.PERIOD_RESET(PERIOD_RESET)) chk (
  .clock(clock), .rst_n(rst_n), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .sleepRequest(sleepRequest),
  .powerMode(powerMode), .subclockIn(subclockIn), .sampleData(sampleData),
  .sampleHold(sampleHold), .frontChannel(frontChannel),
  .frontExternal(frontExternal), .frontVref(frontVref), .irq(irq));
`default_nettype wire

// ---- tb/standby_wake_ctrl_bench.sv ----
// Self-checking bench for the standby wake controller over APB.
// Assumes the checker is bound separately; short timer period.
`default_nettype none
module standby_wake_ctrl_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock, rst_n, psel, penable, pwrite, pready, pslverr, irq, e;
  logic sleepRequest, subclockIn, sampleHold, frontExternal;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, r, c1;
  logic [11:0] sampleData;
  logic [3:0] frontChannel;
  logic [1:0] frontVref;
  logic [2:0] subDiv;
  wake_pkg::power_mode_t powerMode;
  int err_total, n_checks, n;
  logic [7:0] scanTab [5] = '{8'h01, 8'h01, 8'h01, 8'h11, 8'h21};
  logic [11:0] smpTab [5] = '{12'h7FF, 12'h800, 12'hFFF, 12'h000, 12'h123};
  logic [11:0] resTab [5] = '{12'h7FF, 12'h800, 12'hFFF, 12'h000, 12'hFFF};
  standby_wake_ctrl #(.PERIOD_RESET(32'h00000004)) dut (
    .clock(clock), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .sleepRequest(sleepRequest),
    .powerMode(powerMode), .subclockIn(subclockIn), .sampleData(sampleData),
    .sampleHold(sampleHold), .frontChannel(frontChannel),
    .frontExternal(frontExternal), .frontVref(frontVref), .irq(irq));
  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end
  // Slow square wave standing in for the subclock pin
  always @(posedge clock) begin
    subDiv <= subDiv + 3'h1;
    subclockIn <= subDiv[2];
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic xfer(input logic wr, input logic [7:0] a,
      input logic [31:0] d);
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    do begin
      @(posedge clock);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic waitMode(input wake_pkg::power_mode_t m);
    n = 0;
    while (powerMode !== m && n < 3000) begin
      @(posedge clock);
      n++;
    end
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  initial begin
    repeat (30000) @(posedge clock);
    err_total++;
    end_sim();
  end
  initial begin
    {rst_n, psel, penable, pwrite, sleepRequest, subclockIn} = 6'h00;
    paddr = 8'h00;
    pwdata = 32'h00000000;
    sampleData = 12'h000;
    subDiv = 3'h0;
    err_total = 0;
    n_checks = 0;
    repeat (8) @(posedge clock);
    rst_n <= 1'b1;
    xfer(1'b0, wake_pkg::OFF_ADC_LOWER, 0);
    chk(r, 32'h00000800);
    xfer(1'b0, wake_pkg::OFF_ADC_UPPER, 0);
    chk(r, 32'h00000FFF);
    xfer(1'b0, wake_pkg::OFF_ADC_SCAN, 0);
    chk(r, 32'h00000001);
    xfer(1'b0, wake_pkg::OFF_IRQ_MASK, 0);
    chk(r, 32'h00000000);
    xfer(1'b0, 8'h40, 0);
    chk({r[30:0], e}, 32'h00000001);
    $display("test reset done");
    xfer(1'b1, wake_pkg::OFF_TIMER_PERIOD, 1000);
    xfer(1'b1, wake_pkg::OFF_TIMER_CTRL, 32'h00000001);
    repeat (97) @(posedge clock);
    xfer(1'b0, wake_pkg::OFF_TIMER_COUNT, 0);
    chk(32'(r >= 9 && r <= 14), 1);
    xfer(1'b1, wake_pkg::OFF_TIMER_CTRL, 0);
    xfer(1'b0, wake_pkg::OFF_TIMER_COUNT, 0);
    chk(r, 0);
    xfer(1'b1, wake_pkg::OFF_TIMER_PERIOD, 1000);
    xfer(1'b1, wake_pkg::OFF_TIMER_CTRL, 32'h0000000B);
    xfer(1'b0, wake_pkg::OFF_TIMER_COUNT, 0);
    c1 = r;
    repeat (37) @(posedge clock);
    xfer(1'b0, wake_pkg::OFF_TIMER_COUNT, 0);
    chk(r - c1, 10);
    xfer(1'b1, wake_pkg::OFF_TIMER_CTRL, 0);
    xfer(1'b1, wake_pkg::OFF_TIMER_CTRL, 32'h00000003);
    xfer(1'b0, wake_pkg::OFF_TIMER_COUNT, 0);
    chk(32'(r <= 4), 1);
    $display("test timer done");
    xfer(1'b1, wake_pkg::OFF_TIMER_PERIOD, 50);
    xfer(1'b0, wake_pkg::OFF_IRQ_STATUS, 0);
    xfer(1'b1, wake_pkg::OFF_IRQ_MASK, 32'h00000001);
    n = 0;
    while (irq !== 1'b1 && n < 500) begin
      @(posedge clock);
      n++;
    end
    chk(32'(irq), 1);
    xfer(1'b0, wake_pkg::OFF_IRQ_STATUS, 0);
    chk(32'(r[0]), 1);
    xfer(1'b0, wake_pkg::OFF_IRQ_STATUS, 0);
    chk(32'(r[0]), 0);
    xfer(1'b1, wake_pkg::OFF_IRQ_MASK, 0);
    repeat (2) @(posedge clock);
    chk(32'(irq), 0);
    xfer(1'b1, wake_pkg::OFF_TIMER_CTRL, 0);
    xfer(1'b0, wake_pkg::OFF_IRQ_STATUS, 0);
    $display("test interrupt done");
    for (int i = 0; i < 5; i++) begin
      xfer(1'b1, wake_pkg::OFF_ADC_SCAN, 32'(scanTab[i]));
      sampleData <= smpTab[i];
      xfer(1'b1, wake_pkg::OFF_ADC_CTRL, 32'h00000010);
      xfer(1'b1, wake_pkg::OFF_ADC_CTRL, 32'h00000011);
      @(posedge clock);
      xfer(1'b0, wake_pkg::OFF_ADC_STATUS, 0);
      chk(32'(r[0]), 1);
      n = 0;
      while (sampleHold !== 1'b0 && n < 500) begin
        @(posedge clock);
        n++;
      end
      xfer(1'b0, wake_pkg::OFF_ADC_RESULT, 0);
      chk(r, 32'(resTab[i]));
      xfer(1'b0, wake_pkg::OFF_IRQ_STATUS, 0);
      chk(r, (resTab[i] >= 12'h800) ? 32'h6 : 32'hC);
    end
    $display("test convert done");
    sampleData <= 12'h100;
    xfer(1'b1, wake_pkg::OFF_ADC_SCAN, 32'h00000001);
    xfer(1'b1, wake_pkg::OFF_ADC_CTRL, 32'h00000005);
    xfer(1'b0, wake_pkg::OFF_IRQ_STATUS, 0);
    xfer(1'b1, wake_pkg::OFF_IRQ_MASK, 32'h00000002);
    xfer(1'b1, wake_pkg::OFF_TIMER_PERIOD, 300);
    xfer(1'b1, wake_pkg::OFF_TIMER_CTRL, 32'h00000003);
    xfer(1'b1, wake_pkg::OFF_ADC_CTRL, 32'h00000007);
    sleepRequest <= 1'b1;
    @(posedge clock);
    sleepRequest <= 1'b0;
    waitMode(wake_pkg::PM_SNOOZE);
    chk(32'(powerMode), 32'(wake_pkg::PM_SNOOZE));
    waitMode(wake_pkg::PM_STANDBY);
    chk(32'(powerMode), 32'(wake_pkg::PM_STANDBY));
    sampleData <= 12'h900;
    waitMode(wake_pkg::PM_NORMAL);
    chk(32'(n > 200), 1);
    chk(32'(powerMode), 32'(wake_pkg::PM_NORMAL));
    // The interrupt level trails the mode change by one cycle
    @(posedge clock);
    chk(32'(irq), 1);
    xfer(1'b0, wake_pkg::OFF_ADC_RESULT, 0);
    chk(r, 32'h00000900);
    xfer(1'b1, wake_pkg::OFF_ADC_CTRL, 32'h00000005);
    xfer(1'b1, wake_pkg::OFF_ADC_CTRL, 0);
    xfer(1'b1, wake_pkg::OFF_TIMER_CTRL, 0);
    xfer(1'b1, wake_pkg::OFF_IRQ_MASK, 0);
    repeat (2) @(posedge clock);
    chk(32'(irq), 0);
    $display("test snooze done");
    end_sim();
  end
endmodule // standby_wake_ctrl_bench
`default_nettype wire
